// *** verilog/txl_pkg.sv ***
// Purpose: Constants shared by the texel expander and LOD control block.
// Assumes: 32-bit register port, byte addresses, one word per register.
// Notes: Register map, field positions, codes and values hold the numbers the logic uses.
package txl_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_LOD = 8'h04;
  localparam logic [7:0] OFS_PALETTE = 8'h08;
  localparam logic [7:0] OFS_NCC = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] LOD_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_WMASK = 32'h7fff_ffff;
  localparam logic [31:0] LOD_WMASK = 32'h37ff_ffff;
  // ==========================================================
  // Field positions
  localparam int MODE_MINF = 1;
  localparam int MODE_MAGF = 2;
  localparam int MODE_NCCSEL = 5;
  localparam int MODE_FMT = 8;
  localparam int MODE_RGBC = 12;
  localparam int MODE_AC = 21;
  localparam int LOD_MIN = 0;
  localparam int LOD_MAX = 6;
  localparam int LOD_BIAS = 12;
  localparam int LOD_ODD = 18;
  localparam int LOD_SPLIT = 19;
  localparam int LOD_SWIDER = 20;
  localparam int LOD_ASPECT = 21;
  localparam int LOD_ZFRAC = 23;
  localparam int LOD_MBASE = 24;
  localparam int LOD_SWIZZLE = 25;
  localparam int LOD_SWAP = 26;
  localparam int LOD_MIRS = 28;
  localparam int LOD_MIRT = 29;
  localparam int PAL_IDX = 24;
  localparam int NCC_TBL = 31;
  localparam int NCC_KIND = 29;
  localparam int NCC_IDX = 24;
  // ==========================================================
  // Codes and values
  localparam logic [5:0] LOD_CAP = 6'h20;
  localparam logic [7:0] ALPHA_OPAQUE = 8'hff;
  localparam logic [1:0] NCC_KIND_Y = 2'h0;
  localparam logic [1:0] NCC_KIND_I = 2'h1;
  localparam logic [1:0] NCC_KIND_Q = 2'h2;
  localparam logic [1:0] BASE_LAST = 2'h3;
  typedef enum logic [3:0] {
    FMT_RGB332, FMT_NCC8, FMT_A8, FMT_I8, FMT_AI44, FMT_PAL, FMT_PALA, FMT_RSV7,
    FMT_ARGB8332, FMT_NCC16, FMT_RGB565, FMT_ARGB1555, FMT_ARGB4444, FMT_AI88,
    FMT_APAL, FMT_RSV15
  } txl_fmt_type;

  // Upper half of the code space holds the 16-bit formats
  function automatic logic fmt_is_wide(input logic [3:0] fmt);
    return fmt[3];
  endfunction
endpackage

// *** verilog/txl_texel_if.sv ***
// Purpose: Carries one texel and its lookups to the expander and back.
// Assumes: Purely combinational path inside one clock domain.
// Notes: The feeding side registers the answer.
`timescale 1ns/1ps
interface txl_texel_if;
  logic [3:0] fmt;
  logic [15:0] texel;
  logic [23:0] pal;
  logic [23:0] ncc_rgb;
  logic [31:0] argb;
  modport feed (output fmt, output texel, output pal, output ncc_rgb, input argb);
  modport expand (input fmt, input texel, input pal, input ncc_rgb, output argb);
endinterface

// *** verilog/txl_expand.sv ***
// Purpose: Expands one raw texel to 32-bit ARGB by format code.
// Assumes: Palette entry and compression colour already looked up.
// Notes: Combinational; reserved codes give zero.
`timescale 1ns/1ps
module txl_expand (
  // Texel in, colour out
  txl_texel_if.expand tx
);
  function automatic logic [7:0] x2(input logic [1:0] v);
    return {v, v, v, v};
  endfunction
  function automatic logic [7:0] x3(input logic [2:0] v);
    return {v, v, v[2:1]};
  endfunction
  function automatic logic [7:0] x4(input logic [3:0] v);
    return {v, v};
  endfunction
  function automatic logic [7:0] x5(input logic [4:0] v);
    return {v, v[4:2]};
  endfunction
  function automatic logic [7:0] x6(input logic [5:0] v);
    return {v, v[5:4]};
  endfunction

  wire [7:0] lo = tx.texel[7:0];
  wire [7:0] hi = tx.texel[15:8];
  wire [15:0] t = tx.texel;
  wire [23:0] p = tx.pal;

  always_comb begin
    unique case (txl_pkg::txl_fmt_type'(tx.fmt))
      txl_pkg::FMT_RGB332: tx.argb = {txl_pkg::ALPHA_OPAQUE, x3(lo[7:5]), x3(lo[4:2]), x2(lo[1:0])};
      txl_pkg::FMT_NCC8: tx.argb = {txl_pkg::ALPHA_OPAQUE, tx.ncc_rgb};
      txl_pkg::FMT_A8: tx.argb = {lo, lo, lo, lo};
      txl_pkg::FMT_I8: tx.argb = {txl_pkg::ALPHA_OPAQUE, lo, lo, lo};
      txl_pkg::FMT_AI44: tx.argb = {x4(lo[7:4]), x4(lo[3:0]), x4(lo[3:0]), x4(lo[3:0])};
      txl_pkg::FMT_PAL: tx.argb = {txl_pkg::ALPHA_OPAQUE, p};
      txl_pkg::FMT_PALA: tx.argb = {x6(p[23:18]), x6(p[17:12]), x6(p[11:6]), x6(p[5:0])};
      txl_pkg::FMT_ARGB8332: tx.argb = {hi, x3(lo[7:5]), x3(lo[4:2]), x2(lo[1:0])};
      txl_pkg::FMT_NCC16: tx.argb = {hi, tx.ncc_rgb};
      txl_pkg::FMT_RGB565: tx.argb = {txl_pkg::ALPHA_OPAQUE, x5(t[15:11]), x6(t[10:5]), x5(t[4:0])};
      txl_pkg::FMT_ARGB1555: tx.argb = {{8{t[15]}}, x5(t[14:10]), x5(t[9:5]), x5(t[4:0])};
      txl_pkg::FMT_ARGB4444: tx.argb = {x4(t[15:12]), x4(t[11:8]), x4(t[7:4]), x4(t[3:0])};
      txl_pkg::FMT_AI88: tx.argb = {hi, lo, lo, lo};
      txl_pkg::FMT_APAL: tx.argb = {hi, p};
      default: tx.argb = 32'h0000_0000;
    endcase
  end
endmodule // txl_expand

// *** verilog/txl_lod_expand.sv ***
// Purpose: Texel reorder and expansion, LOD bias and clamp, control registers.
// Assumes: Texel and LOD requests are one-cycle strobes with their data.
// Notes: Texel answer two edges after the request, LOD answer one edge after.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module txl_lod_expand (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Texture memory read data
  input wire logic tex_valid,
  input wire logic [31:0] tex_word,
  input wire logic [1:0] tex_lane,
  // Texture download data
  input wire logic dl_valid,
  input wire logic [31:0] dl_word,
  output logic dl_valid_out,
  output logic [31:0] dl_word_out,
  output logic dl_wide,
  // Expanded texel
  output logic texel_valid,
  output logic [31:0] texel_argb,
  // LOD request
  input wire logic lod_valid,
  input wire logic [5:0] lod_calc,
  // LOD result
  output logic lod_out_valid,
  output logic [5:0] lod_out,
  output logic lod_minify,
  output logic lod_bilinear,
  output logic lod_level_present,
  output logic [1:0] lod_base_sel,
  // Addressing controls
  output logic [1:0] lod_aspect,
  output logic s_axis_wider,
  output logic mirror_s,
  output logic mirror_t,
  // Combine unit controls
  output logic [26:0] rgb_combine_fields,
  output logic [8:0] alpha_combine_fields
);
  // ==========================================================
  // Control registers
  logic [31:0] texture_mode_control;
  logic [31:0] lod_control;
  logic [23:0] palette [256];
  logic [7:0] ncc_y [2][16];
  logic [7:0] ncc_i [2][4];
  logic [7:0] ncc_q [2][4];

  wire wr_mode = reg_wr && (reg_addr == txl_pkg::OFS_MODE);
  wire wr_lod = reg_wr && (reg_addr == txl_pkg::OFS_LOD);
  wire wr_pal = reg_wr && (reg_addr == txl_pkg::OFS_PALETTE);
  wire wr_ncc = reg_wr && (reg_addr == txl_pkg::OFS_NCC);
  wire [7:0] pal_widx = reg_wdata[txl_pkg::PAL_IDX +: 8];
  wire ncc_wtbl = reg_wdata[txl_pkg::NCC_TBL];
  wire [1:0] ncc_wkind = reg_wdata[txl_pkg::NCC_KIND +: 2];
  wire [3:0] ncc_widx = reg_wdata[txl_pkg::NCC_IDX +: 4];

  wire [3:0] fmt = texture_mode_control[txl_pkg::MODE_FMT +: 4];
  wire ncc_sel = texture_mode_control[txl_pkg::MODE_NCCSEL];
  wire [5:0] lod_min = lod_control[txl_pkg::LOD_MIN +: 6];
  wire [5:0] lod_max = lod_control[txl_pkg::LOD_MAX +: 6];
  wire [5:0] lod_bias = lod_control[txl_pkg::LOD_BIAS +: 6];
  wire swizzle = lod_control[txl_pkg::LOD_SWIZZLE];
  wire swap = lod_control[txl_pkg::LOD_SWAP];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      texture_mode_control <= txl_pkg::MODE_RESET;
      lod_control <= txl_pkg::LOD_RESET;
    end else begin
      if (wr_mode) begin
        texture_mode_control <= reg_wdata & txl_pkg::MODE_WMASK;
      end
      if (wr_lod) begin
        lod_control <= reg_wdata & txl_pkg::LOD_WMASK;
      end
    end
  end

  // Table storage is data, not control, so it carries no reset
  always_ff @(posedge clock) begin
    if (wr_pal) begin
      palette[pal_widx] <= reg_wdata[23:0];
    end
    if (wr_ncc && ncc_wkind == txl_pkg::NCC_KIND_Y) begin
      ncc_y[ncc_wtbl][ncc_widx] <= reg_wdata[7:0];
    end
    if (wr_ncc && ncc_wkind == txl_pkg::NCC_KIND_I) begin
      ncc_i[ncc_wtbl][ncc_widx[1:0]] <= reg_wdata[7:0];
    end
    if (wr_ncc && ncc_wkind == txl_pkg::NCC_KIND_Q) begin
      ncc_q[ncc_wtbl][ncc_widx[1:0]] <= reg_wdata[7:0];
    end
  end

  // ==========================================================
  // Register read, data in the cycle after the strobe
  wire [31:0] status = {21'h00_0000, texel_valid, lod_minify, lod_level_present,
                        lod_base_sel, lod_out};
  wire [31:0] next_rdata =
    !reg_rd ? 32'h0000_0000 :
    (reg_addr == txl_pkg::OFS_MODE) ? texture_mode_control :
    (reg_addr == txl_pkg::OFS_LOD) ? lod_control :
    (reg_addr == txl_pkg::OFS_STATUS) ? status : 32'h0000_0000;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Incoming data reorder
  function automatic logic [31:0] reorder(input logic [31:0] w, input logic bsw,
                                          input logic hsw);
    logic [31:0] b;
    b = bsw ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    return hsw ? {b[15:0], b[31:16]} : b;
  endfunction

  wire [31:0] tex_ordered = reorder(tex_word, swizzle, swap);

  // Downloads see the same reorder and the same format width
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dl_valid_out <= 1'b0;
      dl_word_out <= 32'h0000_0000;
      dl_wide <= 1'b0;
    end else begin
      dl_valid_out <= dl_valid;
      dl_word_out <= reorder(dl_word, swizzle, swap);
      dl_wide <= txl_pkg::fmt_is_wide(fmt);
    end
  end

  // ==========================================================
  // Texel stage one: capture reordered word and format
  logic s1_valid;
  logic [31:0] s1_word;
  logic [1:0] s1_lane;
  logic [3:0] s1_fmt;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_valid <= 1'b0;
      s1_word <= 32'h0000_0000;
      s1_lane <= 2'h0;
      s1_fmt <= 4'h0;
    end else begin
      s1_valid <= tex_valid;
      s1_word <= tex_ordered;
      s1_lane <= tex_lane;
      s1_fmt <= fmt;
    end
  end

  // ==========================================================
  // Texel stage two: lane pick, lookups, expansion
  wire [7:0] lane_byte = s1_word[{s1_lane, 3'h0} +: 8];
  wire [15:0] lane_half = s1_lane[1] ? s1_word[31:16] : s1_word[15:0];
  wire [15:0] texel = txl_pkg::fmt_is_wide(s1_fmt) ? lane_half : {8'h00, lane_byte};

  function automatic logic [7:0] sat_add(input logic [7:0] y, input logic [7:0] d);
    logic [9:0] s;
    s = {2'b00, y} + {{2{d[7]}}, d};
    return s[9] ? 8'h00 : (s[8] ? 8'hff : s[7:0]);
  endfunction

  wire [7:0] ncc_luma = ncc_y[ncc_sel][texel[7:4]];
  wire [7:0] ncc_red = sat_add(ncc_luma, ncc_i[ncc_sel][texel[3:2]]);
  wire [7:0] ncc_blue = sat_add(ncc_luma, ncc_q[ncc_sel][texel[1:0]]);

  txl_texel_if tx ();
  assign tx.fmt = s1_fmt;
  assign tx.texel = texel;
  assign tx.pal = palette[texel[7:0]];
  assign tx.ncc_rgb = {ncc_red, ncc_luma, ncc_blue};

  txl_expand u_expand (
    .tx(tx.expand)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      texel_valid <= 1'b0;
      texel_argb <= 32'h0000_0000;
    end else begin
      texel_valid <= s1_valid;
      texel_argb <= tx.argb;
    end
  end

  // ==========================================================
  // LOD bias and clamp
  wire [7:0] lod_sum = {2'b00, lod_calc} + {{2{lod_bias[5]}}, lod_bias};
  wire below_min = $signed(lod_sum) < $signed({2'b00, lod_min});
  wire [5:0] lod_ceil = (lod_max < txl_pkg::LOD_CAP) ? lod_max : txl_pkg::LOD_CAP;
  wire above_max = $signed(lod_sum) > $signed({2'b00, lod_ceil});
  wire [5:0] lod_clamped = below_min ? lod_min : (above_max ? lod_ceil : lod_sum[5:0]);
  wire zero_frac = lod_control[txl_pkg::LOD_ZFRAC];
  wire [5:0] next_lod = zero_frac ? {lod_clamped[5:2], 2'b00} : lod_clamped;
  wire [3:0] level = next_lod[5:2];
  wire split = lod_control[txl_pkg::LOD_SPLIT];
  wire odd = lod_control[txl_pkg::LOD_ODD];
  wire next_present = !split || (level[0] == odd);
  wire multibase = lod_control[txl_pkg::LOD_MBASE];
  wire [1:0] next_base = !multibase ? 2'h0 :
                         (level >= 4'(txl_pkg::BASE_LAST)) ? txl_pkg::BASE_LAST : level[1:0];
  wire next_minify = !below_min;
  wire next_bilinear = next_minify ? texture_mode_control[txl_pkg::MODE_MINF]
                                   : texture_mode_control[txl_pkg::MODE_MAGF];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lod_out_valid <= 1'b0;
      lod_out <= 6'h00;
      lod_minify <= 1'b0;
      lod_bilinear <= 1'b0;
      lod_level_present <= 1'b0;
      lod_base_sel <= 2'h0;
    end else begin
      lod_out_valid <= lod_valid;
      if (lod_valid) begin
        lod_out <= next_lod;
        lod_minify <= next_minify;
        lod_bilinear <= next_bilinear;
        lod_level_present <= next_present;
        lod_base_sel <= next_base;
      end
    end
  end

  // ==========================================================
  // Addressing and combine controls
  wire [1:0] aspect = lod_control[txl_pkg::LOD_ASPECT +: 2];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lod_aspect <= 2'h0;
      s_axis_wider <= 1'b0;
      mirror_s <= 1'b0;
      mirror_t <= 1'b0;
      alpha_combine_fields <= 9'h000;
    end else begin
      lod_aspect <= aspect;
      s_axis_wider <= (aspect != 2'h0) && lod_control[txl_pkg::LOD_SWIDER];
      mirror_s <= lod_control[txl_pkg::LOD_MIRS];
      mirror_t <= lod_control[txl_pkg::LOD_MIRT];
      alpha_combine_fields <= texture_mode_control[txl_pkg::MODE_AC +: 9];
    end
  end

  // One copy of the shared colour field group per colour channel
  // Each unit owns its flops, so every slice of the bus has one writer
  for (genvar ch = 0; ch < 3; ch++) begin : g_rgb_unit
    logic [8:0] unit_fields;
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        unit_fields <= 9'h000;
      end else begin
        unit_fields <= texture_mode_control[txl_pkg::MODE_RGBC +: 9];
      end
    end
    assign rgb_combine_fields[ch*9 +: 9] = unit_fields;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_byte_reverse: assert property (
    tex_valid && swizzle && !swap |=>
      s1_word == {$past(tex_word[7:0]), $past(tex_word[15:8]),
                  $past(tex_word[23:16]), $past(tex_word[31:24])})
    else $error("byte reversal wrong");
  a_swap_after: assert property (
    tex_valid && swizzle && swap |=>
      s1_word == {$past(tex_word[23:16]), $past(tex_word[31:24]),
                  $past(tex_word[7:0]), $past(tex_word[15:8])})
    else $error("half exchange not after byte reversal");
  a_half_swap: assert property (
    tex_valid && !swizzle && swap |=> s1_word == {$past(tex_word[15:0]), $past(tex_word[31:16])})
    else $error("half exchange wrong");
  a_lod_floor: assert property (
    lod_valid && !zero_frac && !wr_lod |=> lod_out >= $past(lod_min))
    else $error("LOD below minimum");
  a_lod_ceiling: assert property (
    lod_valid |=> lod_out <= txl_pkg::LOD_CAP && lod_out <= $past(lod_max) || $past(below_min))
    else $error("LOD above ceiling");
  a_filter_pick: assert property (
    lod_valid |=> lod_minify == ($signed($past(lod_sum)) >= $signed({2'b00, $past(lod_min)})))
    else $error("filter choice wrong");
  a_zero_frac: assert property (
    lod_valid && zero_frac |=> lod_out[1:0] == 2'b00)
    else $error("fraction not forced to zero");
  a_single_base: assert property (
    lod_valid && !multibase |=> lod_base_sel == 2'h0)
    else $error("base select without multibase");
  a_square_wider: assert property (
    $past(aspect) == 2'h0 |-> !s_axis_wider)
    else $error("S wider set for square texture");
  a_palette_alpha: assert property (
    s1_valid && s1_fmt == 4'(txl_pkg::FMT_PAL) |=> texel_valid && texel_argb[31:24] == 8'hff)
    else $error("palette alpha not opaque");
  a_texel_latency: assert property (
    tex_valid |-> ##2 texel_valid)
    else $error("texel answer late");
  a_all_levels: assert property (
    lod_valid && !split |=> lod_level_present)
    else $error("level missing without split");
  a_level_parity: assert property (
    lod_valid && split |=> lod_level_present == (lod_out[2] == $past(odd)))
    else $error("level parity wrong");
  a_base_pick: assert property (
    lod_valid && multibase |=>
      lod_base_sel == ((lod_out[5:2] >= 4'h3) ? 2'h3 : lod_out[3:2]))
    else $error("base select wrong for level");
  a_mirror_copy: assert property (
    mirror_s == $past(lod_control[txl_pkg::LOD_MIRS]) &&
      mirror_t == $past(lod_control[txl_pkg::LOD_MIRT]))
    else $error("mirror bits not following control");
  a_aspect_copy: assert property (
    lod_aspect == $past(aspect))
    else $error("aspect not following control");
  // Read data stands only in the cycle after a read strobe
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  c_palette_rgba: cover property (tex_valid && fmt == 4'(txl_pkg::FMT_PALA));
  c_clamp_min: cover property (lod_valid && below_min);
  c_both_reorder: cover property (tex_valid && swizzle && swap);
  c_split_missing: cover property (lod_valid ##1 !lod_level_present);
  c_multibase_cap: cover property (lod_valid && multibase ##1 lod_base_sel == txl_pkg::BASE_LAST);
endmodule // txl_lod_expand

// *** tb/txl_texmem_model.sv ***
// Purpose: Texture memory stand-in that returns one raw word per fetch.
// Assumes: The bench asks for a fetch one cycle before the word is due.
// Notes: Idle data lines toggle so a stale word can never pass as fresh.
`timescale 1ns/1ps
module txl_texmem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fetch command from the bench
  input wire logic fetch,
  input wire logic [31:0] fetch_word,
  input wire logic [1:0] fetch_lane,
  // Texture memory read data
  output logic tex_valid,
  output logic [31:0] tex_word,
  output logic [1:0] tex_lane
);
  // ==========================================================
  // Read data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tex_valid <= 1'b0;
      tex_word <= 32'h0000_0000;
      tex_lane <= 2'h0;
    end else if (fetch) begin
      tex_valid <= 1'b1;
      tex_word <= fetch_word;
      tex_lane <= fetch_lane;
    end else begin
      // Released bus: inverse of the last value, not a held copy
      tex_valid <= 1'b0;
      tex_word <= ~tex_word;
      tex_lane <= ~tex_lane;
    end
  end
endmodule // txl_texmem_model

// *** tb/tb_texel_expand_lod_control.sv ***
// Purpose: Self-checking bench for texel expansion, reorder and LOD control.
// Assumes: One 200 MHz clock, synchronous active-low reset.
// Notes: Expected colours are worked out by hand from the format table.
`timescale 1ns/1ps
module tb_texel_expand_lod_control;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fetch = 1'b0;
  logic [31:0] fetch_word = 32'h0000_0000;
  logic [1:0] fetch_lane = 2'h0;
  logic dl_valid = 1'b0;
  logic [31:0] dl_word = 32'h0000_0000;
  logic lod_valid = 1'b0;
  logic [5:0] lod_calc = 6'h00;
  logic [31:0] reg_rdata, tex_word, dl_word_out, texel_argb;
  logic [1:0] tex_lane, lod_base_sel, lod_aspect;
  logic tex_valid, dl_valid_out, dl_wide, texel_valid, lod_out_valid, lod_minify;
  logic lod_bilinear, lod_level_present, s_axis_wider, mirror_s, mirror_t;
  logic [5:0] lod_out;
  logic [26:0] rgb_combine_fields;
  logic [8:0] alpha_combine_fields;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] fmt_exp [16] = '{32'hffb6_2455, 32'hff50_4030, 32'ha5a5_a5a5, 32'hffa5_a5a5,
    32'haa55_5555, 32'hff12_3456, 32'h108e_4559, 32'h0000_0000, 32'h56b6_2455, 32'h5650_4030,
    32'hff52_d729, 32'h00ad_ad29, 32'h5566_aa55, 32'h56a5_a5a5, 32'h5612_3456, 32'h0000_0000};

  txl_lod_expand i_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tex_valid, .tex_word, .tex_lane, .dl_valid, .dl_word, .dl_valid_out, .dl_word_out,
    .dl_wide, .texel_valid, .texel_argb, .lod_valid, .lod_calc, .lod_out_valid, .lod_out,
    .lod_minify, .lod_bilinear, .lod_level_present, .lod_base_sel, .lod_aspect, .s_axis_wider,
    .mirror_s, .mirror_t, .rgb_combine_fields, .alpha_combine_fields);
  txl_texmem_model i_mem (.clock, .rst_n, .fetch, .fetch_word, .fetch_lane, .tex_valid,
    .tex_word, .tex_lane);

  // ==========================================================
  // Clock and hang guard
  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      tally_and_finish;
    end
  end

  // ==========================================================
  // Access tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobe is dropped one edge early so the next call never reassigns it in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check(what, reg_rdata, exp);
    @(posedge clock);
  endtask
  task automatic texel(input logic [31:0] w, input logic [1:0] lane, input logic [31:0] dexp,
                       input logic [31:0] exp);
    fetch <= 1'b1;
    fetch_word <= w;
    fetch_lane <= lane;
    dl_valid <= 1'b1;
    dl_word <= w;
    @(posedge clock);
    fetch <= 1'b0;
    dl_valid <= 1'b0;
    #1 check("download valid", {31'h0, dl_valid_out}, 32'h0000_0001);
    check("download word", dl_word_out, dexp);
    // Memory answers one edge after the fetch, the expander two edges after that
    repeat (2) @(posedge clock);
    #1 check("texel valid", {31'h0, texel_valid}, 32'h0000_0001);
    check("texel argb", texel_argb, exp);
    @(posedge clock);
  endtask
  task automatic lod(input logic [5:0] c, input logic [10:0] exp);
    lod_valid <= 1'b1;
    lod_calc <= c;
    @(posedge clock);
    lod_valid <= 1'b0;
    #1 check("lod result", {20'h0, lod_out_valid, lod_out, lod_minify, lod_bilinear,
      lod_level_present, lod_base_sel}, {20'h0, 1'b1, exp});
    @(posedge clock);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(txl_pkg::OFS_LOD, 32'h0000_0000, "lod reset");
    rd(8'h14, 32'h0000_0000, "unmapped read");
    wr(txl_pkg::OFS_LOD, 32'hffff_ffff);
    rd(txl_pkg::OFS_LOD, 32'h37ff_ffff, "lod readback");
    check("addressing", {27'h0, lod_aspect, s_axis_wider, mirror_s, mirror_t}, 32'h1f);
    wr(txl_pkg::OFS_LOD, 32'h1010_0000);
    // Addressing outputs follow the register one edge after the write lands
    @(posedge clock);
    // Square texture: the wider-axis bit must be ignored
    check("addressing", {27'h0, lod_aspect, s_axis_wider, mirror_s, mirror_t}, 32'h2);
    wr(txl_pkg::OFS_MODE, 32'h2aa5_5000);
    @(posedge clock);
    check("rgb combine", {5'h0, rgb_combine_fields}, {5'h0, {3{9'h055}}});
    check("alpha combine", {23'h0, alpha_combine_fields}, {23'h0, 9'h155});
    rd(txl_pkg::OFS_MODE, 32'h2aa5_5000, "mode readback");
    wr(txl_pkg::OFS_LOD, 32'h0000_0000);
    wr(txl_pkg::OFS_PALETTE, 32'ha512_3456);
    wr(txl_pkg::OFS_NCC, 32'h0a00_0040);
    wr(txl_pkg::OFS_NCC, 32'h2100_0010);
    wr(txl_pkg::OFS_NCC, 32'h4100_00f0);
    for (int i = 0; i < 16; i++) begin
      wr(txl_pkg::OFS_MODE, {20'h0, i[3:0], 8'h00});
      texel(32'h0000_56a5, 2'h0, 32'h0000_56a5, fmt_exp[i]);
      check("wide format", {31'h0, dl_wide}, {31'h0, i[3]});
    end
    // Second compression table, picked by the mode select bit
    wr(txl_pkg::OFS_NCC, 32'h8a00_0080);
    wr(txl_pkg::OFS_NCC, 32'ha100_0000);
    wr(txl_pkg::OFS_NCC, 32'hc100_0000);
    wr(txl_pkg::OFS_MODE, 32'h0000_0120);
    texel(32'h0000_00a5, 2'h0, 32'h0000_00a5, 32'hff80_8080);
    // Intensity format shows exactly which byte survives the reorder
    wr(txl_pkg::OFS_MODE, 32'h0000_0300);
    texel(32'h1122_3344, 2'h2, 32'h1122_3344, 32'hff22_2222);
    wr(txl_pkg::OFS_LOD, 32'h0200_0000);
    texel(32'h1122_3344, 2'h0, 32'h4433_2211, 32'hff11_1111);
    wr(txl_pkg::OFS_LOD, 32'h0400_0000);
    texel(32'h1122_3344, 2'h0, 32'h3344_1122, 32'hff22_2222);
    wr(txl_pkg::OFS_LOD, 32'h0600_0000);
    texel(32'h1122_3344, 2'h0, 32'h2211_4433, 32'hff33_3333);
    wr(txl_pkg::OFS_MODE, 32'h0000_0002);
    wr(txl_pkg::OFS_LOD, 32'h0103_8a04);
    lod(6'd10, {6'd4, 1'b0, 1'b0, 1'b1, 2'd1});
    lod(6'd0, {6'd4, 1'b0, 1'b0, 1'b1, 2'd1});
    lod(6'd12, {6'd4, 1'b1, 1'b1, 1'b1, 2'd1});
    lod(6'd60, {6'd32, 1'b1, 1'b1, 1'b1, 2'd3});
    wr(txl_pkg::OFS_LOD, 32'h0088_0504);
    lod(6'd23, {6'd20, 1'b1, 1'b1, 1'b0, 2'd0});
    lod(6'd10, {6'd8, 1'b1, 1'b1, 1'b1, 2'd0});
    lod(6'd62, {6'd20, 1'b1, 1'b1, 1'b0, 2'd0});
    rd(txl_pkg::OFS_STATUS, 32'h0000_0214, "status");
    tally_and_finish;
  end
endmodule // tb_texel_expand_lod_control
